// File: dv/cls_lock_checker.sv
// concurrent checks on the ports of the lock and start-up register bank
`timescale 1ns/10ps
module cls_lock_checker (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic ccp_open,
  input wire logic port_a_analog_enable,
  input wire logic port_b_analog_enable,
  input wire logic [2:0] port_a_stage_en,
  input wire logic [2:0] port_b_stage_en,
  input wire logic [7:0] event_channel_wr_req,
  input wire logic [7:0] event_channel_wr_allow,
  input wire logic waveform_ext_c_wr_req,
  input wire logic waveform_ext_c_wr_allow,
  input wire logic waveform_ext_e_wr_req,
  input wire logic waveform_ext_e_wr_allow,
  input wire logic event_lower_channels_lock,
  input wire logic event_upper_channels_lock,
  input wire logic waveform_ext_port_c_lock,
  input wire logic waveform_ext_port_e_lock
);
  import cls_pkg::*;
  // ----------------------------------------------------------------
  // gating, locks and read-back
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic lo, up, pc, pe;
  assign lo = event_lower_channels_lock;
  assign up = event_upper_channels_lock;
  assign pc = waveform_ext_port_c_lock;
  assign pe = waveform_ext_port_e_lock;
  chk_lower_gate: assert property (event_channel_wr_allow[3:0] == (event_channel_wr_req[3:0] & ~{4{lo}}))
    else $error("lower channel gate wrong");
  chk_upper_gate: assert property (event_channel_wr_allow[7:4] == (event_channel_wr_req[7:4] & ~{4{up}}))
    else $error("upper channel gate wrong");
  chk_port_c_gate: assert property (waveform_ext_c_wr_allow == (waveform_ext_c_wr_req & !pc))
    else $error("port c gate wrong");
  chk_port_e_gate: assert property (waveform_ext_e_wr_allow == (waveform_ext_e_wr_req & !pe))
    else $error("port e gate wrong");
  chk_lock_protect: assert property (($rose(lo) || $rose(up) || $rose(pc) || $rose(pe)) |-> $past(reg_wr && ccp_open))
    else $error("lock set without protected write");
  chk_lock_sticky: assert property (!($fell(lo) || $fell(up) || $fell(pc) || $fell(pe)))
    else $error("lock cleared without reset");
  chk_evt_read: assert property (reg_rd && reg_addr == CLS_EVENT_CHANNEL_LOCK_OFS |=> reg_rdata == {3'h0, up, 3'h0, lo})
    else $error("event lock read wrong");
  chk_wext_read: assert property (reg_rd && reg_addr == CLS_WAVEFORM_EXT_LOCK_OFS |=> reg_rdata == {5'h00, pe, 1'b0, pc})
    else $error("waveform lock read wrong");
  // ----------------------------------------------------------------
  // port a start-up stages and coverage
  // ----------------------------------------------------------------
  chk_stage_order: assert property (port_a_stage_en inside {3'h0, 3'h1, 3'h3, 3'h7})
    else $error("stages out of order");
  chk_stage_off: assert property (!port_a_analog_enable |=> port_a_stage_en == 3'h0)
    else $error("stages stay on after disable");
  cov_lower_lock: cover property ($rose(lo));
  cov_ramp_done: cover property ($rose(port_a_stage_en[2]));
  cov_unprot_wr: cover property (reg_wr && !ccp_open && reg_addr == CLS_EVENT_CHANNEL_LOCK_OFS);
endmodule : cls_lock_checker

bind cls_lock_startup_regs cls_lock_checker u_chk (.*);

// File: dv/tb_cls_lock_startup_regs.sv
// self-checking bench for the lock and start-up register bank
`timescale 1ns/10ps
module tb_cls_lock_startup_regs;
  import cls_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0, ccp_open = 1'b0;
  logic port_a_analog_enable = 1'b0, port_b_analog_enable = 1'b0;
  logic [2:0] port_a_stage_en, port_b_stage_en;
  logic [7:0] event_channel_wr_req = 8'hFF, event_channel_wr_allow;
  logic waveform_ext_c_wr_req = 1'b1, waveform_ext_c_wr_allow;
  logic waveform_ext_e_wr_req = 1'b1, waveform_ext_e_wr_allow;
  logic event_lower_channels_lock, event_upper_channels_lock;
  logic waveform_ext_port_c_lock, waveform_ext_port_e_lock;
  int n_errors = 0;
  int checks_done = 0;
  int spc [4] = '{0, 2, 8, 32};

  cls_lock_startup_regs u_dut (.*);

  initial begin
    forever #50 core_clk = ~core_clk;
  end
  // ----------------------------------------------------------------
  // bus and compare helpers
  // ----------------------------------------------------------------
  task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [7:0] d, input logic p);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    ccp_open <= p;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    ccp_open <= 1'b0;
  endtask : wr

  // read data stand one cycle only, then fall back to zero
  task rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(what, reg_rdata, exp);
    @(posedge core_clk);
    #1 chk("rdata idle", reg_rdata, 8'h00);
  endtask : rd

  task reset_dut;
    nrst <= 1'b0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
  endtask : reset_dut
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task s_reset_values;
    rd(CLS_ANALOG_INIT_OFS, CLS_REG_RESET, "init reset");
    rd(CLS_EVENT_CHANNEL_LOCK_OFS, 8'h00, "evt reset");
    rd(CLS_WAVEFORM_EXT_LOCK_OFS, 8'h00, "wext reset");
    wr(8'h0B, 8'hFF, 1'b1);
    rd(8'h0B, 8'h00, "unmapped");
  endtask : s_reset_values

  task s_unprotected;
    wr(CLS_EVENT_CHANNEL_LOCK_OFS, 8'h11, 1'b0);
    wr(CLS_WAVEFORM_EXT_LOCK_OFS, 8'h05, 1'b0);
    rd(CLS_EVENT_CHANNEL_LOCK_OFS, 8'h00, "evt unprot");
    rd(CLS_WAVEFORM_EXT_LOCK_OFS, 8'h00, "wext unprot");
    chk("allow open", event_channel_wr_allow, 8'hFF);
    @(posedge core_clk);
    event_channel_wr_req <= 8'h5A;
    waveform_ext_c_wr_req <= 1'b0;
    @(posedge core_clk);
    #1 chk("allow follows req", event_channel_wr_allow, 8'h5A);
    chk("wext req", 8'({waveform_ext_c_wr_allow, waveform_ext_e_wr_allow}), 8'h01);
    @(posedge core_clk);
    event_channel_wr_req <= 8'hFF;
    waveform_ext_c_wr_req <= 1'b1;
  endtask : s_unprotected

  task s_event_locks;
    wr(CLS_EVENT_CHANNEL_LOCK_OFS, 8'h01, 1'b1);
    rd(CLS_EVENT_CHANNEL_LOCK_OFS, 8'h01, "evt lower");
    chk("allow lower", event_channel_wr_allow, 8'hF0);
    wr(CLS_EVENT_CHANNEL_LOCK_OFS, 8'h10, 1'b1);
    rd(CLS_EVENT_CHANNEL_LOCK_OFS, 8'h11, "evt both");
    chk("allow upper", event_channel_wr_allow, 8'h00);
    wr(CLS_EVENT_CHANNEL_LOCK_OFS, 8'h00, 1'b1);
    rd(CLS_EVENT_CHANNEL_LOCK_OFS, 8'h11, "evt sticky");
  endtask : s_event_locks

  task s_wext_locks;
    wr(CLS_WAVEFORM_EXT_LOCK_OFS, 8'h01, 1'b1);
    rd(CLS_WAVEFORM_EXT_LOCK_OFS, 8'h01, "wext c");
    chk("c allow", 8'({waveform_ext_c_wr_allow, waveform_ext_e_wr_allow}), 8'h01);
    wr(CLS_WAVEFORM_EXT_LOCK_OFS, 8'h04, 1'b1);
    rd(CLS_WAVEFORM_EXT_LOCK_OFS, 8'h05, "wext e");
    chk("e allow", 8'({waveform_ext_c_wr_allow, waveform_ext_e_wr_allow}), 8'h00);
  endtask : s_wext_locks

  // stage spacing is counted in edges from the edge that drives enable high
  task s_startup(input logic [1:0] code, input int s);
    int t1;
    int t2;
    t1 = 0;
    t2 = 0;
    wr(CLS_ANALOG_INIT_OFS, {4'h0, code, code}, 1'b0);
    rd(CLS_ANALOG_INIT_OFS, {4'h0, code, code}, "init sel");
    @(posedge core_clk);
    port_a_analog_enable <= 1'b1;
    port_b_analog_enable <= 1'b1;
    for (int k = 1; k <= 80 && t2 == 0; k++) begin
      @(posedge core_clk);
      #1 if (k == 1) chk("ref step", 8'(port_a_stage_en[0]), 8'h01);
      if (t1 == 0 && port_a_stage_en[1] === 1'b1) t1 = k;
      if (port_a_stage_en[2] === 1'b1) t2 = k;
      chk("port b", 8'(port_b_stage_en), (k > 2 * s) ? 8'h07 : (k > s) ? 8'h03 : 8'h01);
    end
    chk("bias step", 8'(t1), 8'(s + 1));
    chk("ready step", 8'(t2), 8'(2 * s + 1));
    if (t2 == 0) summarize();
    @(posedge core_clk);
    port_a_analog_enable <= 1'b0;
    port_b_analog_enable <= 1'b0;
    @(posedge core_clk);
    #1 chk("stages off", 8'({port_a_stage_en, port_b_stage_en}), 8'h00);
  endtask : s_startup

  task s_reset_mid;
    reset_dut();
    rd(CLS_EVENT_CHANNEL_LOCK_OFS, 8'h00, "evt cleared");
    rd(CLS_WAVEFORM_EXT_LOCK_OFS, 8'h00, "wext cleared");
    chk("allow after reset", event_channel_wr_allow, 8'hFF);
  endtask : s_reset_mid

  task summarize;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize

  initial begin
    reset_dut();
    s_reset_values();
    s_unprotected();
    s_event_locks();
    s_wext_locks();
    for (int i = 0; i < 4; i++) s_startup(2'(i), spc[i]);
    s_reset_mid();
    summarize();
  end

  // a hang is cut short here and counted as a mismatch
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    summarize();
  end
endmodule : tb_cls_lock_startup_regs

// File: src/cls_lock_startup_regs.sv
// lock registers and analog start-up delay control for the system-control block
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
module cls_lock_startup_regs (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic ccp_open,
  input wire logic port_a_analog_enable,
  input wire logic port_b_analog_enable,
  output logic [2:0] port_a_stage_en,
  output logic [2:0] port_b_stage_en,
  input wire logic [7:0] event_channel_wr_req,
  output logic [7:0] event_channel_wr_allow,
  input wire logic waveform_ext_c_wr_req,
  output logic waveform_ext_c_wr_allow,
  input wire logic waveform_ext_e_wr_req,
  output logic waveform_ext_e_wr_allow,
  output logic event_lower_channels_lock,
  output logic event_upper_channels_lock,
  output logic waveform_ext_port_c_lock,
  output logic waveform_ext_port_e_lock
);
  import cls_pkg::*;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic wr_init;
  logic wr_evt;
  logic wr_wext;

  // the selector register is open to any write
  assign wr_init = reg_wr && (reg_addr == CLS_ANALOG_INIT_OFS);
  // unprotected writes to the lock registers are dropped silently
  assign wr_evt = reg_wr && ccp_open && (reg_addr == CLS_EVENT_CHANNEL_LOCK_OFS);
  assign wr_wext = reg_wr && ccp_open && (reg_addr == CLS_WAVEFORM_EXT_LOCK_OFS);

  // ----------------------------------------------------------------
  // analog start-up delay selectors
  // ----------------------------------------------------------------
  logic [1:0] sel_a_ff, nxt_sel_a;
  logic [1:0] sel_b_ff, nxt_sel_b;

  always_comb begin
    nxt_sel_a = sel_a_ff;
    nxt_sel_b = sel_b_ff;
    // a code written mid-ramp only applies at the next start of that port
    if (wr_init) begin
      nxt_sel_a = reg_wdata[CLS_SEL_A_LSB +: CLS_SEL_W];
      nxt_sel_b = reg_wdata[CLS_SEL_B_LSB +: CLS_SEL_W];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sel_a_ff <= CLS_DLY_NONE;
      sel_b_ff <= CLS_DLY_NONE;
    end else begin
      sel_a_ff <= nxt_sel_a;
      sel_b_ff <= nxt_sel_b;
    end
  end

  // ----------------------------------------------------------------
  // event channel locks
  // ----------------------------------------------------------------
  logic evt_lo_ff, nxt_evt_lo;
  logic evt_hi_ff, nxt_evt_hi;

  // a lock once set holds until reset; a protected write of zero cannot release it
  always_comb begin
    nxt_evt_lo = evt_lo_ff;
    nxt_evt_hi = evt_hi_ff;
    if (wr_evt) begin
      nxt_evt_lo = evt_lo_ff | reg_wdata[CLS_EVT_LOWER_BIT];
      nxt_evt_hi = evt_hi_ff | reg_wdata[CLS_EVT_UPPER_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      evt_lo_ff <= 1'b0;
      evt_hi_ff <= 1'b0;
    end else begin
      evt_lo_ff <= nxt_evt_lo;
      evt_hi_ff <= nxt_evt_hi;
    end
  end

  // ----------------------------------------------------------------
  // waveform extension locks
  // ----------------------------------------------------------------
  logic wext_c_ff, nxt_wext_c;
  logic wext_e_ff, nxt_wext_e;

  // same sticky behaviour as the event locks
  always_comb begin
    nxt_wext_c = wext_c_ff;
    nxt_wext_e = wext_e_ff;
    if (wr_wext) begin
      nxt_wext_c = wext_c_ff | reg_wdata[CLS_WEXT_C_BIT];
      nxt_wext_e = wext_e_ff | reg_wdata[CLS_WEXT_E_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wext_c_ff <= 1'b0;
      wext_e_ff <= 1'b0;
    end else begin
      wext_c_ff <= nxt_wext_c;
      wext_e_ff <= nxt_wext_e;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [7:0] rdata_ff, nxt_rdata;

  // reserved and unmapped positions fall out as zero from the cleared default
  always_comb begin
    nxt_rdata = CLS_REG_RESET;
    if (reg_rd) begin
      unique case (reg_addr)
        CLS_ANALOG_INIT_OFS: begin
          nxt_rdata[CLS_SEL_A_LSB +: CLS_SEL_W] = sel_a_ff;
          nxt_rdata[CLS_SEL_B_LSB +: CLS_SEL_W] = sel_b_ff;
        end
        CLS_EVENT_CHANNEL_LOCK_OFS: begin
          nxt_rdata[CLS_EVT_LOWER_BIT] = evt_lo_ff;
          nxt_rdata[CLS_EVT_UPPER_BIT] = evt_hi_ff;
        end
        CLS_WAVEFORM_EXT_LOCK_OFS: begin
          nxt_rdata[CLS_WEXT_C_BIT] = wext_c_ff;
          nxt_rdata[CLS_WEXT_E_BIT] = wext_e_ff;
        end
        default: begin
          nxt_rdata = CLS_REG_RESET;
        end
      endcase
    end
  end

  // data stand one cycle only, so a stale value never looks like a fresh read
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= CLS_REG_RESET;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // ----------------------------------------------------------------
  // write gating toward the locked registers
  // ----------------------------------------------------------------
  // gating is combinational so a request in the cycle after the lock sets is already refused
  always_comb begin
    event_channel_wr_allow = event_channel_wr_req;
    for (int i = 0; i < CLS_CHANNELS; i++) begin
      if (i < CLS_CHANNELS_PER_LOCK) begin
        event_channel_wr_allow[i] = event_channel_wr_req[i] && !evt_lo_ff;
      end else begin
        event_channel_wr_allow[i] = event_channel_wr_req[i] && !evt_hi_ff;
      end
    end
  end

  assign waveform_ext_c_wr_allow = waveform_ext_c_wr_req && !wext_c_ff;
  assign waveform_ext_e_wr_allow = waveform_ext_e_wr_req && !wext_e_ff;

  // ----------------------------------------------------------------
  // lock status outputs
  // ----------------------------------------------------------------
  assign event_lower_channels_lock = evt_lo_ff;
  assign event_upper_channels_lock = evt_hi_ff;
  assign waveform_ext_port_c_lock = wext_c_ff;
  assign waveform_ext_port_e_lock = wext_e_ff;

  // ----------------------------------------------------------------
  // analog start-up sequencers, one per port
  // ----------------------------------------------------------------
  cls_seq_if seq_a_if ();
  cls_seq_if seq_b_if ();

  // one sequencer per port so each port ramps on its own enable
  assign seq_a_if.start_sel = sel_a_ff;
  assign seq_a_if.enable = port_a_analog_enable;
  assign seq_b_if.start_sel = sel_b_ff;
  assign seq_b_if.enable = port_b_analog_enable;

  cls_startup_seq u_seq_a (
    .core_clk(core_clk),
    .nrst(nrst),
    .sq(seq_a_if.seq)
  );

  cls_startup_seq u_seq_b (
    .core_clk(core_clk),
    .nrst(nrst),
    .sq(seq_b_if.seq)
  );

  assign port_a_stage_en = seq_a_if.stages;
  assign port_b_stage_en = seq_b_if.stages;

endmodule : cls_lock_startup_regs

// File: src/cls_pkg.sv
// constants and types shared by the lock and start-up register bank
package cls_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CLS_ANALOG_INIT_OFS = 8'h07;
  localparam logic [7:0] CLS_EVENT_CHANNEL_LOCK_OFS = 8'h08;
  localparam logic [7:0] CLS_WAVEFORM_EXT_LOCK_OFS = 8'h09;
  localparam logic [7:0] CLS_REG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CLS_SEL_A_LSB = 0;
  localparam int CLS_SEL_B_LSB = 2;
  localparam int CLS_SEL_W = 2;
  localparam int CLS_EVT_LOWER_BIT = 0;
  localparam int CLS_EVT_UPPER_BIT = 4;
  localparam int CLS_WEXT_C_BIT = 0;
  localparam int CLS_WEXT_E_BIT = 2;
  localparam int CLS_CHANNELS = 8;
  localparam int CLS_CHANNELS_PER_LOCK = 4;
  localparam int CLS_STAGES = 3;

  // ----------------------------------------------------------------
  // start-up delay selector codes and spacings in peripheral clocks
  // ----------------------------------------------------------------
  localparam logic [1:0] CLS_DLY_NONE = 2'h0;
  localparam logic [1:0] CLS_DLY_2CLK = 2'h1;
  localparam logic [1:0] CLS_DLY_8CLK = 2'h2;
  localparam logic [1:0] CLS_DLY_32CLK = 2'h3;
  localparam int CLS_CNT_W = 6;
  localparam logic [CLS_CNT_W-1:0] CLS_SPACE_2 = 6'h02;
  localparam logic [CLS_CNT_W-1:0] CLS_SPACE_8 = 6'h08;
  localparam logic [CLS_CNT_W-1:0] CLS_SPACE_32 = 6'h20;
  localparam logic [CLS_CNT_W-1:0] CLS_CNT_ONE = 6'h01;
  localparam logic [CLS_CNT_W-1:0] CLS_CNT_ZERO = 6'h00;

  typedef enum logic [2:0] {
    CLS_SQ_OFF = 3'b001,
    CLS_SQ_RAMP = 3'b010,
    CLS_SQ_ON = 3'b100
  } cls_seq_state_e;

  // spacing between two successive start-up stages for a selector code
  function automatic logic [CLS_CNT_W-1:0] cls_spacing(input logic [1:0] sel);
    logic [CLS_CNT_W-1:0] s;
    s = CLS_SPACE_2;
    unique case (sel)
      CLS_DLY_2CLK: s = CLS_SPACE_2;
      CLS_DLY_8CLK: s = CLS_SPACE_8;
      CLS_DLY_32CLK: s = CLS_SPACE_32;
      CLS_DLY_NONE: s = CLS_CNT_ONE;
    endcase
    return s;
  endfunction : cls_spacing

endpackage : cls_pkg

// File: src/cls_seq_if.sv
// link between the register bank and one analog start-up sequencer
`timescale 1ns/10ps
interface cls_seq_if;
  logic [1:0] start_sel;
  logic enable;
  logic [2:0] stages;

  modport seq (input start_sel, input enable, output stages);
  modport ctl (output start_sel, output enable, input stages);
endinterface : cls_seq_if

// File: src/cls_startup_seq.sv
// sequential start of reference, bias and ready stages for one analog port
`timescale 1ns/10ps
module cls_startup_seq (
  input wire logic core_clk,
  input wire logic nrst,
  cls_seq_if.seq sq
);
  import cls_pkg::*;

  cls_seq_state_e state_ff, nxt_state;
  logic [CLS_CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [CLS_CNT_W-1:0] space_ff, nxt_space;
  logic [CLS_STAGES-1:0] stages_ff, nxt_stages;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_space = space_ff;
    nxt_stages = stages_ff;
    unique case (state_ff)
      CLS_SQ_OFF: begin
        if (sq.enable) begin
          if (sq.start_sel == CLS_DLY_NONE) begin
            nxt_stages = '1;
            nxt_state = CLS_SQ_ON;
          end else begin
            // selector is latched so a change mid-ramp cannot skew spacing
            nxt_space = cls_spacing(sq.start_sel);
            nxt_cnt = cls_spacing(sq.start_sel) - CLS_CNT_ONE;
            nxt_stages = {{(CLS_STAGES-1){1'b0}}, 1'b1};
            nxt_state = CLS_SQ_RAMP;
          end
        end
      end
      CLS_SQ_RAMP: begin
        if (!sq.enable) begin
          nxt_stages = '0;
          nxt_state = CLS_SQ_OFF;
        end else if (cnt_ff == CLS_CNT_ZERO) begin
          nxt_stages = {stages_ff[CLS_STAGES-2:0], 1'b1};
          nxt_cnt = space_ff - CLS_CNT_ONE;
          if (stages_ff[CLS_STAGES-2]) begin
            nxt_state = CLS_SQ_ON;
          end
        end else begin
          nxt_cnt = cnt_ff - CLS_CNT_ONE;
        end
      end
      CLS_SQ_ON: begin
        if (!sq.enable) begin
          nxt_stages = '0;
          nxt_state = CLS_SQ_OFF;
        end
      end
      default: begin
        nxt_stages = '0;
        nxt_state = CLS_SQ_OFF;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= CLS_SQ_OFF;
      cnt_ff <= CLS_CNT_ZERO;
      space_ff <= CLS_CNT_ONE;
      stages_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      space_ff <= nxt_space;
      stages_ff <= nxt_stages;
    end
  end

  assign sq.stages = stages_ff;

endmodule : cls_startup_seq
